/* File: src/kms_cfg.svh */
`ifndef KMS_CFG_SVH
`define KMS_CFG_SVH

// matrix geometry
`define KMS_ROWS 8
`define KMS_COLS 6
// key codes run 0 .. rows*cols-1
`define KMS_CODE_COUNT 48
// column lines read all ones when no key is closed
`define KMS_COL_IDLE 6'h3F
// one-hot pattern of row 0 output enable
`define KMS_ROW0_OE 8'h01
`define KMS_ROW_NONE 8'h00

// system clock period
`define KMS_CLK_NS 10
// least time a row stays driven low
`define KMS_ROW_TIME_NS 100000
// least release time between two row pulses
`define KMS_GAP_TIME_NS 1000
// least times round up to whole cycles
`define KMS_ROW_CYC ((`KMS_ROW_TIME_NS + `KMS_CLK_NS - 1) / `KMS_CLK_NS)
`define KMS_GAP_CYC ((`KMS_GAP_TIME_NS + `KMS_CLK_NS - 1) / `KMS_CLK_NS)

// full matrix scans a change must stay stable before it is accepted
`define KMS_DEB_SCANS 4

`endif

/* File: src/kms_pkg.sv */
package kms_pkg;

  // row scan sequencer states
  typedef enum logic [1:0] {
    KMS_ST_IDLE  = 2'b00,
    KMS_ST_DRIVE = 2'b01,
    KMS_ST_GAP   = 2'b10
  } kms_state_t;

  // one decoded key position
  typedef struct packed {
    logic valid;
    logic [2:0] row;
    logic [2:0] col;
  } kms_key_t;

endpackage

/* File: src/kms_debounce.sv */
`timescale 1ns/1ps
// accepts a sampled word once it has been seen on n consecutive enables
module kms_debounce #(
  parameter int W = 7,
  parameter int N = 4
) (
  input wire logic mclk_in, // system clock
  input wire logic rst_in, // synchronous reset, active high
  input wire logic en_in, // one-cycle sample enable
  input wire logic [W-1:0] d_in, // raw sample
  output logic [W-1:0] q_out, // accepted value
  output logic q_vld_out // high once a first value was accepted
);

  localparam int CW = $clog2(N + 1);
  localparam logic [CW-1:0] N_C = CW'(N);

  logic [W-1:0] last_r, last_nxt; // most recent sample
  logic [CW-1:0] cnt_r, cnt_nxt; // run length of equal samples
  logic [W-1:0] q_r, q_nxt; // accepted value
  logic vld_r, vld_nxt; // first acceptance seen

  // next-state: count a run of equal samples, accept on the n-th
  always_comb begin
    last_nxt = last_r;
    cnt_nxt = cnt_r;
    q_nxt = q_r;
    vld_nxt = vld_r;
    if (en_in) begin
      if (d_in != last_r) begin
        // a change restarts the run, so bounce never gets through
        last_nxt = d_in;
        cnt_nxt = CW'(1);
      end else if (cnt_r < N_C) begin
        cnt_nxt = cnt_r + CW'(1);
      end
      if (cnt_nxt == N_C) begin
        q_nxt = last_nxt;
        vld_nxt = 1'b1;
      end
    end
  end

  // registers only
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      last_r <= '0;
      cnt_r <= '0;
      q_r <= '0;
      vld_r <= 1'b0;
    end else begin
      last_r <= last_nxt;
      cnt_r <= cnt_nxt;
      q_r <= q_nxt;
      vld_r <= vld_nxt;
    end
  end

  assign q_out = q_r;
  assign q_vld_out = vld_r;

endmodule

/* File: src/kms_scanner.sv */
`timescale 1ns/1ps
`include "kms_cfg.svh"

// Operation
// - drive one row at a time, in turn
// - sample all columns during each row pulse
// - high column is open, low is closed
// - key code from row and column index
// - rows tri-state, drive only low pulse
// - six columns by eight rows matrix
// - register knob steps from rotation pulses
// - report each push level change after the first accepted level as event
module kms_scanner #(
  parameter int ROW_CYC = `KMS_ROW_CYC, // cycles a row is driven
  parameter int GAP_CYC = `KMS_GAP_CYC, // cycles between row pulses
  parameter int DEB_SCANS = `KMS_DEB_SCANS // stable scans before accept
) (
  input wire logic mclk_in, // system clock, 100 MHz
  input wire logic rst_in, // synchronous reset, active high
  output logic [`KMS_ROWS-1:0] row_out, // row drive value, always low
  output logic [`KMS_ROWS-1:0] row_oe_out, // row output enable, high drives
  input wire logic [`KMS_COLS-1:0] col_in, // pulled-up column lines
  input wire logic knob_a_in, // knob rotation pulse a
  input wire logic knob_b_in, // knob rotation pulse b
  input wire logic knob_push_in, // knob push level
  input wire logic key_ack_in, // clears the key event flag
  output kms_pkg::kms_key_t key_out, // debounced key position
  output logic [5:0] key_code_out, // code row*6+col of debounced key
  output logic key_evt_out, // pulse: new key pressed
  output logic key_flag_out, // sticky key event flag
  output logic rot_step_out, // pulse: one rotation step
  output logic rot_dir_out, // step direction, 1 when a leads
  output logic push_level_out, // debounced push level
  output logic push_evt_out // pulse: push level changed
);

  localparam int CNTW = 16;
  localparam logic [CNTW-1:0] ROW_LAST = CNTW'(ROW_CYC - 1);
  localparam logic [CNTW-1:0] GAP_LAST = CNTW'(GAP_CYC - 1);
  localparam logic [2:0] ROW_MAX = 3'(`KMS_ROWS - 1);
  localparam logic [5:0] COL_N = 6'(`KMS_COLS);

  // input synchronisers, two flops per pin
  logic [`KMS_COLS-1:0] col_m_r, col_s_r; // column two-flop sync
  logic [2:0] knob_m_r, knob_s_r; // {push, b, a} two-flop sync

  // first flop feeds only the second; nothing else reads it
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      col_m_r <= `KMS_COL_IDLE;
      col_s_r <= `KMS_COL_IDLE;
      knob_m_r <= 3'h0;
      knob_s_r <= 3'h0;
    end else begin
      col_m_r <= col_in;
      col_s_r <= col_m_r;
      knob_m_r <= {knob_push_in, knob_b_in, knob_a_in};
      knob_s_r <= knob_m_r;
    end
  end

  // row scan sequencer
  kms_pkg::kms_state_t st_r, st_nxt; // sequencer state
  logic [CNTW-1:0] cnt_r, cnt_nxt; // cycles within drive or gap
  logic [2:0] row_r, row_nxt; // row being scanned
  logic [`KMS_ROWS-1:0] oe_r, oe_nxt; // registered row enables
  kms_pkg::kms_key_t cand_r, cand_nxt; // first closed key this frame
  kms_pkg::kms_key_t frame_r, frame_nxt; // result of last whole frame
  logic frame_en_r, frame_en_nxt; // pulse: frame result ready
  logic samp_w; // column sample instant
  logic [2:0] low_col_w; // lowest column index read low

  // lowest-numbered low column wins when several keys share a row
  always_comb begin
    low_col_w = 3'h0;
    for (int i = `KMS_COLS - 1; i >= 0; i--) begin
      if (!col_s_r[i]) begin
        low_col_w = 3'(i);
      end
    end
  end

  // sample at the end of the pulse, so the two sync stages have settled
  assign samp_w = (st_r == kms_pkg::KMS_ST_DRIVE) && (cnt_r == ROW_LAST);

  // next-state of the scan
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    row_nxt = row_r;
    cand_nxt = cand_r;
    frame_nxt = frame_r;
    frame_en_nxt = 1'b0;
    case (st_r)
      kms_pkg::KMS_ST_IDLE: begin
        // start a fresh frame at row 0
        st_nxt = kms_pkg::KMS_ST_DRIVE;
        cnt_nxt = '0;
        row_nxt = 3'h0;
        cand_nxt = '0;
      end
      kms_pkg::KMS_ST_DRIVE: begin
        if (samp_w) begin
          // any low column means a closed key on this row
          if (!cand_r.valid && (col_s_r != `KMS_COL_IDLE)) begin
            cand_nxt.valid = 1'b1;
            cand_nxt.row = row_r;
            cand_nxt.col = low_col_w;
          end
          st_nxt = kms_pkg::KMS_ST_GAP;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + CNTW'(1);
        end
      end
      kms_pkg::KMS_ST_GAP: begin
        // release time lets the column pull-ups recover
        if (cnt_r == GAP_LAST) begin
          st_nxt = kms_pkg::KMS_ST_DRIVE;
          cnt_nxt = '0;
          if (row_r == ROW_MAX) begin
            row_nxt = 3'h0;
            frame_nxt = cand_r;
            frame_en_nxt = 1'b1;
            cand_nxt = '0;
          end else begin
            row_nxt = row_r + 3'h1;
          end
        end else begin
          cnt_nxt = cnt_r + CNTW'(1);
        end
      end
      default: begin
        st_nxt = kms_pkg::KMS_ST_IDLE;
      end
    endcase
    // only the scanned row is enabled, and only while driving
    if (st_nxt == kms_pkg::KMS_ST_DRIVE) begin
      oe_nxt = `KMS_ROW0_OE << row_nxt;
    end else begin
      oe_nxt = `KMS_ROW_NONE;
    end
  end

  // registers only
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_r <= kms_pkg::KMS_ST_IDLE;
      cnt_r <= '0;
      row_r <= 3'h0;
      oe_r <= `KMS_ROW_NONE;
      cand_r <= '0;
      frame_r <= '0;
      frame_en_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      row_r <= row_nxt;
      oe_r <= oe_nxt;
      cand_r <= cand_nxt;
      frame_r <= frame_nxt;
      frame_en_r <= frame_en_nxt;
    end
  end

  // rows only ever pull low; the wire floats high otherwise
  assign row_out = `KMS_ROW_NONE;
  assign row_oe_out = oe_r;

  // debouncers, one sample per frame
  kms_pkg::kms_key_t key_db_w; // accepted key of the matrix
  logic push_db_w; // accepted push level
  logic push_vld_w; // push level accepted at least once

  // one sample per full frame, so stability is counted in scans
  kms_debounce #(.W(7), .N(DEB_SCANS)) u_key_deb (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .en_in(frame_en_r),
    .d_in(frame_r),
    .q_out(key_db_w),
    .q_vld_out()
  );

  kms_debounce #(.W(1), .N(DEB_SCANS)) u_push_deb (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .en_in(frame_en_r),
    .d_in(knob_s_r[2]),
    .q_out(push_db_w),
    .q_vld_out(push_vld_w)
  );

  // events and knob decoding
  kms_pkg::kms_key_t key_r, key_nxt; // key output register
  logic [5:0] code_r, code_nxt; // key code output register
  logic kevt_r, kevt_nxt; // key event pulse
  logic kflag_r, kflag_nxt; // sticky key flag
  logic push_r, push_nxt; // push level output
  logic pseen_r, pseen_nxt; // first push level already taken
  logic pevt_r, pevt_nxt; // push event pulse
  logic qa_p_r, qa_p_nxt; // previous synced knob a
  logic step_r, step_nxt; // rotation step pulse
  logic dir_r, dir_nxt; // rotation direction

  // next-state of the user-facing outputs
  always_comb begin
    key_nxt = key_db_w;
    code_nxt = 6'h00;
    if (key_db_w.valid) begin
      code_nxt = 6'({3'h0, key_db_w.row} * COL_N) + {3'h0, key_db_w.col};
    end
    // event only on a newly pressed key, not on release
    kevt_nxt = key_db_w.valid && (key_db_w != key_r);
    // set wins over a clear that lands in the same cycle
    if (kevt_nxt) begin
      kflag_nxt = 1'b1;
    end else if (key_ack_in) begin
      kflag_nxt = 1'b0;
    end else begin
      kflag_nxt = kflag_r;
    end
    // the first accepted level is a baseline, not an event
    push_nxt = push_db_w;
    pseen_nxt = push_vld_w;
    pevt_nxt = pseen_r && (push_db_w != push_r);
    // a step on every edge of a; a^b tells which input leads
    qa_p_nxt = knob_s_r[0];
    step_nxt = knob_s_r[0] != qa_p_r;
    dir_nxt = dir_r;
    if (step_nxt) begin
      dir_nxt = knob_s_r[0] ^ knob_s_r[1];
    end
  end

  // registers only
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      key_r <= '0;
      code_r <= 6'h00;
      kevt_r <= 1'b0;
      kflag_r <= 1'b0;
      push_r <= 1'b0;
      pseen_r <= 1'b0;
      pevt_r <= 1'b0;
      qa_p_r <= 1'b0;
      step_r <= 1'b0;
      dir_r <= 1'b0;
    end else begin
      key_r <= key_nxt;
      code_r <= code_nxt;
      kevt_r <= kevt_nxt;
      kflag_r <= kflag_nxt;
      push_r <= push_nxt;
      pseen_r <= pseen_nxt;
      pevt_r <= pevt_nxt;
      qa_p_r <= qa_p_nxt;
      step_r <= step_nxt;
      dir_r <= dir_nxt;
    end
  end

  assign key_out = key_r;
  assign key_code_out = code_r;
  assign key_evt_out = kevt_r;
  assign key_flag_out = kflag_r;
  assign push_level_out = push_r;
  assign push_evt_out = pevt_r;
  assign rot_step_out = step_r;
  assign rot_dir_out = dir_r;
  // checks on the behaviour above
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  a_one_row_drv: assert property ($onehot0(row_oe_out))
    else $error("more than one row driven");
  a_row_steps: assert property ($changed(row_r) |-> row_r == 3'($past(row_r) + 3'h1))
    else $error("row sequence skipped");
  a_sample_in_pulse: assert property (samp_w |-> row_oe_out == (`KMS_ROW0_OE << row_r))
    else $error("columns sampled outside row pulse");
  a_row_low_only: assert property (row_out == `KMS_ROW_NONE)
    else $error("row driven high");
  a_open_no_key: assert property (
    (samp_w && row_r == 3'h0 && col_s_r == `KMS_COL_IDLE) |=> !cand_r.valid)
    else $error("open columns gave a key");
  a_code_range: assert property (key_out.valid |-> key_code_out < 6'(`KMS_CODE_COUNT))
    else $error("key code out of range");
  a_code_map: assert property (
    key_out.valid |-> key_code_out == 6'({3'h0, key_out.row} * COL_N) + {3'h0, key_out.col})
    else $error("key code does not match row and column");
  a_step_dir: assert property (
    rot_step_out |-> rot_dir_out == ($past(knob_s_r[0]) ^ $past(knob_s_r[1])))
    else $error("wrong rotation direction");
  a_step_cause: assert property ($changed(knob_s_r[0]) |=> rot_step_out)
    else $error("rotation edge lost");
  a_push_change: assert property (push_evt_out |-> $changed(push_level_out))
    else $error("push event without level change");
  a_key_flag: assert property (
    key_evt_out |-> key_flag_out ##1 (key_flag_out || $past(key_ack_in)))
    else $error("key flag not raised");

endmodule

/* File: bench/kms_keypad_model.sv */
`timescale 1ns/1ps
`include "kms_cfg.svh"

// passive switch matrix: one key may be held closed by the bench
module kms_keypad_model (
  input wire logic [`KMS_ROWS-1:0] row_drv_in, // row drive values
  input wire logic [`KMS_ROWS-1:0] row_oe_in, // row enables, high drives
  input wire logic prs_vld_in, // a key is held closed
  input wire logic [2:0] prs_row_in, // row of the closed key
  input wire logic [2:0] prs_col_in, // column of the closed key
  output logic [`KMS_COLS-1:0] col_out // column lines to the scanner
);
  // pull-ups win unless a driven-low row reaches a column through the key
  always_comb begin
    col_out = `KMS_COL_IDLE; // open lines float up
    if (prs_vld_in && row_oe_in[prs_row_in] && !row_drv_in[prs_row_in]) begin
      col_out[prs_col_in] = 1'b0; // path only through a driven row
    end
  end
endmodule

/* File: bench/test_key_matrix_knob_scanner.sv */
`timescale 1ns/1ps
`include "kms_cfg.svh"

module test_key_matrix_knob_scanner;
  localparam int ROW_CYC = 8; // shortened row time
  localparam int GAP_CYC = 2; // shortened gap
  localparam int DEB = 2; // stable frames needed
  localparam int FRAME = `KMS_ROWS * (ROW_CYC + GAP_CYC);
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] row_drv, row_oe, prev_oe;
  logic [5:0] col;
  logic ka = 1'b0, kb = 1'b0, kp = 1'b0, ack = 1'b0;
  logic prs_vld = 1'b0;
  logic [2:0] prs_row = 3'h0, prs_col = 3'h0;
  kms_pkg::kms_key_t key;
  logic [5:0] code;
  logic evt, flag, step, dir, plev, pevt;
  int num_errors = 0;
  int n_tests = 0;

  // 100 MHz clock
  initial begin
    forever #5 mclk = ~mclk;
  end
  // previous row enable, to find the start of a frame
  always @(posedge mclk) begin
    prev_oe <= row_oe;
  end

  kms_scanner #(.ROW_CYC(ROW_CYC), .GAP_CYC(GAP_CYC), .DEB_SCANS(DEB)) kms_scanner_i (
    .mclk_in(mclk), .rst_in(rst), .row_out(row_drv), .row_oe_out(row_oe),
    .col_in(col), .knob_a_in(ka), .knob_b_in(kb), .knob_push_in(kp),
    .key_ack_in(ack), .key_out(key), .key_code_out(code), .key_evt_out(evt),
    .key_flag_out(flag), .rot_step_out(step), .rot_dir_out(dir),
    .push_level_out(plev), .push_evt_out(pevt));
  kms_keypad_model kms_keypad_model_i (
    .row_drv_in(row_drv), .row_oe_in(row_oe), .prs_vld_in(prs_vld),
    .prs_row_in(prs_row), .prs_col_in(prs_col), .col_out(col));

  task conclude;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask

  // selectable handshake signals, so one bounded wait serves all
  function automatic logic pick(input int s);
    case (s)
      0: return evt;
      1: return step;
      2: return pevt;
      default: return row_oe === 8'h01 && prev_oe !== 8'h01;
    endcase
  endfunction

  // bounded wait; running out ends the run as a failure
  task automatic wait_for(input int s, input int lim, output int n);
    bit hit;
    hit = 1'b0;
    n = 0;
    while (!hit && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
      hit = (pick(s) === 1'b1);
    end
    if (!hit) begin
      chk(1'b0, "wait limit ran out");
      conclude();
    end
  endtask

  // one full frame of row pulses and gaps
  task automatic t_scan;
    int n;
    wait_for(3, 2 * FRAME, n);
    for (int r = 0; r < 8; r++) begin
      for (int k = 0; k < ROW_CYC; k++) begin
        chk(row_oe === (8'h01 << r) && row_drv === 8'h00, "row pulse");
        @(posedge mclk);
        #1;
      end
      for (int k = 0; k < GAP_CYC; k++) begin
        chk(row_oe === 8'h00, "row not released");
        @(posedge mclk);
        #1;
      end
    end
    chk(row_oe === 8'h01, "scan did not wrap");
    $display("test scan done");
  endtask

  // press, flag and ack, then release with no event
  task automatic t_key(input logic [2:0] r, input logic [2:0] c);
    int n;
    kms_pkg::kms_key_t exp;
    exp = '{1'b1, r, c};
    @(posedge mclk);
    prs_row <= r;
    prs_col <= c;
    prs_vld <= 1'b1;
    wait_for(0, 6 * FRAME, n);
    chk(key === exp, "key position");
    chk(code === 6'(r * 6 + c), "key code");
    @(posedge mclk);
    #1;
    chk(flag === 1'b1 && evt === 1'b0, "key flag");
    @(posedge mclk);
    ack <= 1'b1;
    @(posedge mclk);
    ack <= 1'b0;
    prs_vld <= 1'b0;
    #1;
    chk(flag === 1'b0, "flag not cleared");
    for (int k = 0; k < 5 * FRAME; k++) begin
      @(posedge mclk);
      #1;
      if (evt !== 1'b0) chk(1'b0, "event on release");
    end
    chk(key.valid === 1'b0 && code === 6'h00, "key not released");
    $display("test key %0d %0d done", r, c);
  endtask

  // ack held high while a key arrives: the set still wins for one cycle
  task automatic t_ack_race;
    int n;
    @(posedge mclk);
    ack <= 1'b1;
    prs_row <= 3'h1;
    prs_col <= 3'h4;
    prs_vld <= 1'b1;
    wait_for(0, 6 * FRAME, n);
    chk(flag === 1'b1 && code === 6'h0A, "set lost to ack");
    @(posedge mclk);
    #1;
    chk(flag === 1'b0, "held ack did not clear");
    @(posedge mclk);
    ack <= 1'b0;
    prs_vld <= 1'b0;
    repeat (4 * FRAME) @(posedge mclk);
    #1;
    chk(key.valid === 1'b0 && flag === 1'b0, "release after race");
    $display("test ack race done");
  endtask

  // change knob a, expect a step three cycles later
  task automatic kstep(input logic a, input logic d);
    int n;
    @(posedge mclk);
    ka <= a;
    wait_for(1, 8, n);
    chk(n == 3 && dir === d, "rotation step");
    @(posedge mclk);
    #1;
    chk(step === 1'b0, "step longer than a cycle");
  endtask

  // change knob b alone, expect no step
  task automatic kbonly(input logic b);
    @(posedge mclk);
    kb <= b;
    for (int k = 0; k < 6; k++) begin
      @(posedge mclk);
      #1;
      if (step !== 1'b0) chk(1'b0, "step from b alone");
    end
  endtask

  // one full quadrature cycle each way
  task automatic t_knob;
    kstep(1'b1, 1'b1);
    kbonly(1'b1);
    kstep(1'b0, 1'b1);
    kbonly(1'b0);
    kbonly(1'b1);
    kstep(1'b1, 1'b0);
    kbonly(1'b0);
    kstep(1'b0, 1'b0);
    $display("test knob done");
  endtask

  // short glitch rejected, held changes reported both ways
  task automatic t_push;
    int n;
    @(posedge mclk);
    kp <= 1'b1;
    // one frame long, so exactly one push sample sees it
    repeat (FRAME) @(posedge mclk);
    kp <= 1'b0;
    for (int k = 0; k < 4 * FRAME; k++) begin
      @(posedge mclk);
      #1;
      if (pevt !== 1'b0) chk(1'b0, "glitch accepted");
    end
    @(posedge mclk);
    kp <= 1'b1;
    wait_for(2, 6 * FRAME, n);
    chk(plev === 1'b1, "push press");
    @(posedge mclk);
    kp <= 1'b0;
    wait_for(2, 6 * FRAME, n);
    chk(plev === 1'b0, "push release");
    $display("test push done");
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_scan();
    t_key(3'h0, 3'h0);
    t_key(3'h7, 3'h5);
    t_key(3'h3, 3'h2);
    t_ack_race();
    t_knob();
    t_push();
    conclude();
  end
endmodule
